// ===== slbc_pkg.sv
package slbc_pkg;

  // Register map of the checker
  localparam logic [7:0] FWD_ERR_COUNT_OFFSET = 8'h25;
  localparam logic [7:0] FWD_ERR_COUNT_RESET  = 8'h00;
  localparam logic [7:0] LINK_DETECT_OFFSET   = 8'h0C;
  localparam int         LINK_DETECT_BIT      = 0;
  localparam logic [7:0] BC_CRC_COUNT_RESET   = 8'h00;

  // Widths
  localparam int PAYLOAD_WIDTH = 35;
  localparam int COUNT_WIDTH   = 8;

  // Timing
  localparam int CORE_CLK_HZ      = 40_000_000;
  localparam int INT_OSC_HZ       = 33_000_000;
  localparam int PAYLOAD_PERIOD   = 2;
  localparam int BC_FRAME_PERIOD  = 16;

  // Result pin levels
  localparam logic RESULT_PASS    = 1'b1;
  localparam logic RESULT_FAIL    = 1'b0;
  localparam logic RESULT_RESET   = 1'b0;

  localparam logic [PAYLOAD_WIDTH-1:0] PAYLOAD_ZERO = 35'h0_0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQUEST,
    ST_CHECK,
    ST_HOLD
  } slbc_state_t;

endpackage

// ===== slbc_link_if.sv
`timescale 1ns/1ps
interface slbc_link_if;
  import slbc_pkg::*;

  // Back channel, deserializer to serializer
  logic                     selfTestReq;
  logic                     bcFrameValid;
  logic                     bcCrcBad;
  // Forward channel, serializer to deserializer
  logic [PAYLOAD_WIDTH-1:0] payload;
  logic                     payloadValid;
  logic                     serInTest;

  modport des (
    output selfTestReq,
    output bcFrameValid,
    output bcCrcBad,
    input  payload,
    input  payloadValid,
    input  serInTest
  );

  modport ser (
    input  selfTestReq,
    input  bcFrameValid,
    input  bcCrcBad,
    output payload,
    output payloadValid,
    output serInTest
  );
endinterface

// ===== slbc_ser.sv
`timescale 1ns/1ps
module slbc_ser #(
  parameter int PAYLOAD_DIV = slbc_pkg::PAYLOAD_PERIOD
) (
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  slbc_link_if.ser                          link,
  input  wire logic                         bcLinkDetect,
  input  wire logic                         injectError,
  input  wire logic                         crcClear,
  output logic                              linkDetectStatus,
  output logic                              inTest,
  output logic [slbc_pkg::COUNT_WIDTH-1:0]  bcCrcErrorCount
);
  import slbc_pkg::*;

  localparam int DW = $clog2(PAYLOAD_DIV + 1);

  logic          reqMeta;
  logic          reqSync;
  logic          reqSyncD;
  logic [DW-1:0] divCount;
  logic          payloadTick;
  logic          testEntry;
  logic          crcEvent;

  //////////////////////////////////////////////////////////////////////////
  // Back-channel enable request crosses in from the far end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqMeta  <= 1'b0;
      reqSync  <= 1'b0;
      reqSyncD <= 1'b0;
    end else begin
      reqMeta  <= link.selfTestReq;
      reqSync  <= reqMeta;
      reqSyncD <= reqSync;
    end
  end

  assign testEntry = reqSync & ~reqSyncD;
  assign crcEvent  = reqSync & bcLinkDetect & link.bcFrameValid &
                     link.bcCrcBad;
  assign inTest    = reqSyncD;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.serInTest   <= 1'b0;
      linkDetectStatus <= 1'b0;
    end else begin
      link.serInTest   <= reqSync;
      linkDetectStatus <= bcLinkDetect;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Payload rate divider
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCount <= '0;
    end else if (divCount == DW'(PAYLOAD_DIV - 1)) begin
      divCount <= '0;
    end else begin
      divCount <= divCount + DW'(1);
    end
  end

  assign payloadTick = (divCount == DW'(PAYLOAD_DIV - 1));

  // Scrambling and balancing sit in the line coder; payload is zeros unless injectError sets bit 0 on a payload tick
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.payload      <= PAYLOAD_ZERO;
      link.payloadValid <= 1'b0;
    end else begin
      link.payloadValid <= payloadTick & reqSync;
      link.payload      <= (payloadTick & injectError) ?
                           {{(PAYLOAD_WIDTH-1){1'b0}}, 1'b1} : PAYLOAD_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Back-channel CRC error record, kept after the run ends
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bcCrcErrorCount <= BC_CRC_COUNT_RESET;
    end else if (testEntry) begin
      // An error on the entry edge belongs to the new run
      bcCrcErrorCount <= crcEvent ? 8'h01 : BC_CRC_COUNT_RESET;
    end else if (crcEvent && bcCrcErrorCount != 8'hFF) begin
      bcCrcErrorCount <= bcCrcErrorCount + 8'h01;
    end else if (crcClear && !reqSync) begin
      bcCrcErrorCount <= BC_CRC_COUNT_RESET;
    end
  end

endmodule // slbc_ser

// ===== slbc_des.sv
`timescale 1ns/1ps
// Behaviour
// - Pin or config bit enters self-test
// - Internal oscillator chosen only without pixel clock
// - Enable request sent over back channel
// - Far end sends all-zeros scrambled payload
// - Both in test and locked: result high
// - Errored 35-bit payload pulses result low
// - Enable low: stop, hold pass or fail
// - Verdict held until new test or reset; a run dropped before check shows fail one cycle, then pass
// - Enable pulse width sets test duration
// - Lock output valid throughout self-test
// - Board straps I/O zero high, others low
// - Link returns to normal after enable low
// - Compare against zeros, count at forward_link_error_count
// - Far end checks CRC after link detect
// - Far end clears 8-bit CRC count on entry
// - Far end counts only in test, keeps result
module slbc_des #(
  parameter int BC_DIV = slbc_pkg::BC_FRAME_PERIOD
) (
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  slbc_link_if.des                          link,
  input  wire logic                         selfTestEnablePin,
  input  wire logic                         selfTestClockSelectPin,
  input  wire logic                         cfgSelfTestEnable,
  input  wire logic                         cfgClockSelect,
  input  wire logic                         pixelClockPresent,
  input  wire logic                         rxLocked,
  input  wire logic                         injectBcError,
  output logic                              resultPin,
  output logic                              lockOut,
  output logic                              useInternalOsc,
  output logic                              normalMode,
  output logic                              checking,
  output logic [slbc_pkg::COUNT_WIDTH-1:0]  forwardLinkErrorCount
);
  import slbc_pkg::*;

  localparam int BW = $clog2(BC_DIV + 1);

  logic        enMeta;
  logic        enSync;
  logic        selMeta;
  logic        selSync;
  logic        testRequest;
  slbc_state_t state;
  slbc_state_t next_state;
  logic        payloadBad;
  logic        anyError;
  logic        errorPulse;
  logic [BW-1:0] bcCount;

  // Any set bit in a payload marks it errored
  function automatic logic payload_has_error(
    input logic [PAYLOAD_WIDTH-1:0] word
  );
    payload_has_error = (word != PAYLOAD_ZERO);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enMeta  <= 1'b0;
      enSync  <= 1'b0;
      selMeta <= 1'b0;
      selSync <= 1'b0;
    end else begin
      enMeta  <= selfTestEnablePin;
      enSync  <= enMeta;
      selMeta <= selfTestClockSelectPin;
      selSync <= selMeta;
    end
  end

  // Either source starts the run; duration is the request width
  assign testRequest = enSync | cfgSelfTestEnable;

  //////////////////////////////////////////////////////////////////////////
  // Test clock source select
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      useInternalOsc <= 1'b0;
    end else begin
      // Pixel clock always wins while present
      useInternalOsc <= ~pixelClockPresent &
                        (selSync | cfgClockSelect);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Run sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE, ST_HOLD: begin
        if (testRequest) begin
          next_state = ST_REQUEST;
        end
      end
      ST_REQUEST: begin
        if (!testRequest) begin
          next_state = ST_HOLD;
        end else if (link.serInTest && rxLocked) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!testRequest) begin
          next_state = ST_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign checking = (state == ST_CHECK);

  //////////////////////////////////////////////////////////////////////////
  // Back-channel enable and frames
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.selfTestReq <= 1'b0;
      normalMode       <= 1'b1;
    end else begin
      // Held for the whole run so a sleeping far end wakes up
      link.selfTestReq <= testRequest;
      normalMode       <= ~testRequest;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bcCount <= '0;
    end else if (bcCount == BW'(BC_DIV - 1)) begin
      bcCount <= '0;
    end else begin
      bcCount <= bcCount + BW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.bcFrameValid <= 1'b0;
      link.bcCrcBad     <= 1'b0;
    end else begin
      link.bcFrameValid <= (bcCount == BW'(BC_DIV - 1));
      link.bcCrcBad     <= (bcCount == BW'(BC_DIV - 1)) & injectBcError;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Payload checking
  assign payloadBad = checking && link.payloadValid &&
                      payload_has_error(link.payload);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      anyError <= 1'b0;
    end else if (state != ST_REQUEST && next_state == ST_REQUEST) begin
      anyError <= 1'b0;
    end else if (payloadBad) begin
      anyError <= 1'b1;
    end
  end

  // Saturates so a long run never wraps back to a clean look
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      forwardLinkErrorCount <= FWD_ERR_COUNT_RESET;
    end else if (state != ST_REQUEST && next_state == ST_REQUEST) begin
      forwardLinkErrorCount <= FWD_ERR_COUNT_RESET;
    end else if (payloadBad && forwardLinkErrorCount != 8'hFF) begin
      forwardLinkErrorCount <= forwardLinkErrorCount + 8'h01;
    end
  end

  // One core cycle stands in for half a pixel period
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      errorPulse <= 1'b0;
    end else begin
      errorPulse <= payloadBad;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result pin
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resultPin <= RESULT_RESET;
    end else begin
      unique case (next_state)
        ST_IDLE: begin
          resultPin <= RESULT_RESET;
        end
        ST_REQUEST: begin
          resultPin <= RESULT_FAIL;
        end
        ST_CHECK: begin
          resultPin <= payloadBad ? RESULT_FAIL : RESULT_PASS;
        end
        ST_HOLD: begin
          // Verdict stays until the next run or reset; a run dropped in ST_REQUEST shows fail one cycle, then pass
          resultPin <= (anyError | payloadBad | (state == ST_REQUEST)) ?
                       RESULT_FAIL : RESULT_PASS;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Lock status passes straight through, test or not
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockOut <= 1'b0;
    end else begin
      lockOut <= rxLocked;
    end
  end

endmodule // slbc_des

// ===== slbc_link_asserts.sv
`timescale 1ns/1ps
module slbc_link_asserts #(
  parameter int BC_DIV = 16
) (
  input wire logic                          core_clk,
  input wire logic                          sys_rst,
  input wire logic                          selfTestReq,
  input wire logic                          bcFrameValid,
  input wire logic                          bcCrcBad,
  input wire logic [slbc_pkg::PAYLOAD_WIDTH-1:0] payload,
  input wire logic                          payloadValid,
  input wire logic                          serInTest
);
  import slbc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  a_ser_enter: assert property (
    $rose(selfTestReq) ##1 selfTestReq [*2] |-> ##1 serInTest)
    else $error("far end did not enter test three cycles after request");
  a_ser_leave: assert property (
    $fell(selfTestReq) ##1 (!selfTestReq) [*2] |-> ##1 !serInTest)
    else $error("far end did not leave test three cycles after drop");
  a_idle_quiet: assert property (
    (!selfTestReq) [*4] |-> !payloadValid)
    else $error("payload sent without a test request");
  a_pv_gap: assert property (
    payloadValid |=> !payloadValid)
    else $error("payloads closer than two cycles");
  a_pv_start: assert property (
    $rose(serInTest) |-> ##[0:2] payloadValid)
    else $error("no payload soon after far end entered test");
  a_frame_gap: assert property (
    bcFrameValid |=> (!bcFrameValid) [*8])
    else $error("back channel frames too close");
  a_frame_period: assert property (
    bcFrameValid |-> ##BC_DIV bcFrameValid)
    else $error("back channel frame period wrong");
  a_crc_in_frame: assert property (
    bcCrcBad |-> bcFrameValid)
    else $error("crc flag outside a frame");
  a_reset_quiet: assert property (
    $fell(sys_rst) |-> !selfTestReq && !serInTest && !payloadValid)
    else $error("link not idle after reset");

  cover property (payloadValid && payload != '0);
  cover property (bcCrcBad);
  cover property ($fell(serInTest));
endmodule // slbc_link_asserts

// ===== serial_link_self_test_checker_bench.sv
`timescale 1ns/1ps
module serial_link_self_test_checker_bench;
  import slbc_pkg::*;
  localparam int BC_DIV = 16;
  // Board straps: I/O zero high, the other three low
  localparam logic [3:0] STRAP_IO = 4'h1;
  localparam logic       STRAP_OK = (STRAP_IO == 4'h1);
  logic       core_clk = 1'b0;
  logic       sys_rst  = 1'b1;
  logic       pin, sel, cfgEn, cfgSel, pcp, locked, injBc;
  logic       linkDet, injErr, crcClr;
  logic       resultPin, lockOut, useOsc, normalMode, checking;
  logic       linkDetectStatus, inTest;
  logic [7:0] fwdCount, crcCount;
  int         nMismatch, checked;

  always #12.5 core_clk = ~core_clk;

  slbc_link_if slbc_link_if_inst ();
  slbc_des #(.BC_DIV(BC_DIV)) slbc_des_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .link(slbc_link_if_inst), .selfTestEnablePin(pin),
    .selfTestClockSelectPin(sel), .cfgSelfTestEnable(cfgEn),
    .cfgClockSelect(cfgSel), .pixelClockPresent(pcp), .rxLocked(locked),
    .injectBcError(injBc), .resultPin(resultPin), .lockOut(lockOut),
    .useInternalOsc(useOsc), .normalMode(normalMode), .checking(checking),
    .forwardLinkErrorCount(fwdCount));
  slbc_ser slbc_ser_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(slbc_link_if_inst), .bcLinkDetect(linkDet),
    .injectError(injErr), .crcClear(crcClr),
    .linkDetectStatus(linkDetectStatus), .inTest(inTest),
    .bcCrcErrorCount(crcCount));
  slbc_link_asserts #(.BC_DIV(BC_DIV)) slbc_link_asserts_inst (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .selfTestReq(slbc_link_if_inst.selfTestReq),
    .bcFrameValid(slbc_link_if_inst.bcFrameValid),
    .bcCrcBad(slbc_link_if_inst.bcCrcBad),
    .payload(slbc_link_if_inst.payload),
    .payloadValid(slbc_link_if_inst.payloadValid),
    .serInTest(slbc_link_if_inst.serInTest));

  //////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      nMismatch++;
    end
  endtask

  task stop_test;
    $display("Checks %0d, mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Bounded wait so a stuck state machine cannot hang the run
  task waitChk(input logic v);
    int k;
    k = 0;
    while (checking !== v && k < 40) begin
      tick(1);
      k++;
    end
    chk("checking", checking, v);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task oscSel;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk) {pcp, sel, cfgSel} <= i[2:0];
      tick(4);
      chk("osc", useOsc, !i[2] && (i[1] || i[0]));
    end
    @(posedge core_clk) pcp <= 1'b1;
  endtask

  task runClean;
    @(posedge core_clk) pin <= STRAP_OK;
    {locked, injBc, linkDet} <= 3'h6;
    waitChk(1'b1);
    chk("result", resultPin, RESULT_PASS);
    chk("lock", lockOut, 1'b1);
    chk("normal", normalMode, 1'b0);
    tick(20);
    chk("result", resultPin, RESULT_PASS);
    chk("lock", lockOut, 1'b1);
    @(posedge core_clk) pin <= 1'b0;
    waitChk(1'b0);
    chk("verdict", resultPin, RESULT_PASS);
    chk("normal", normalMode, 1'b1);
    chk("crc", crcCount, 8'h00);
    tick(10);
    chk("held", resultPin, RESULT_PASS);
  endtask

  task runErrors;
    logic       bad;
    int         exp;
    logic [7:0] crcHeld;
    bad = 1'b0;
    exp = 0;
    @(posedge core_clk) {cfgEn, linkDet} <= 2'h3;
    waitChk(1'b1);
    chk("inTest", inTest, 1'b1);
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk) injErr <= (i >= 4 && i < 10);
      #1;
      chk("pulse", resultPin, !bad);
      bad = checking && slbc_link_if_inst.payloadValid
            && (slbc_link_if_inst.payload !== PAYLOAD_ZERO);
      exp += bad;
    end
    chk("errSeen", exp != 0, 1'b1);
    @(posedge core_clk) {cfgEn, injErr} <= 2'h0;
    waitChk(1'b0);
    chk("verdict", resultPin, RESULT_FAIL);
    chk("fwd", fwdCount, exp[7:0]);
    chk("linkDet", linkDetectStatus, 1'b1);
    // Far end still counts until its synchroniser sees the drop
    tick(4);
    chk("inTest", inTest, 1'b0);
    chk("crcSeen", crcCount != 8'h00, 1'b1);
    crcHeld = crcCount;
    tick(3 * BC_DIV);
    chk("crcHeld", crcCount, crcHeld);
    chk("held", resultPin, RESULT_FAIL);
  endtask

  task retest;
    @(posedge core_clk) {pin, locked, injBc} <= 3'h4;
    tick(12);
    chk("noLock", checking, 1'b0);
    chk("lockLow", lockOut, 1'b0);
    chk("pending", resultPin, RESULT_FAIL);
    @(posedge core_clk) locked <= 1'b1;
    waitChk(1'b1);
    chk("crcClr", crcCount, 8'h00);
    chk("fwdClr", fwdCount, 8'h00);
    chk("result", resultPin, RESULT_PASS);
    @(posedge core_clk) pin <= 1'b0;
    waitChk(1'b0);
    chk("verdict", resultPin, RESULT_PASS);
    // Reset after the run ends wipes the held verdict
    @(posedge core_clk) sys_rst <= 1'b1;
    tick(2);
    chk("rstHold", resultPin, RESULT_RESET);
    @(posedge core_clk) sys_rst <= 1'b0;
    tick(2);
    chk("rstIdle", resultPin, RESULT_RESET);
    chk("rstCheck", checking, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {pin, sel, cfgEn, cfgSel, locked, injBc, linkDet, injErr, crcClr} = '0;
    pcp = 1'b1;
    nMismatch = 0;
    checked = 0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(2);
    chk("rstResult", resultPin, RESULT_RESET);
    chk("rstNormal", normalMode, 1'b1);
    chk("rstFwd", fwdCount, FWD_ERR_COUNT_RESET);
    chk("rstCrc", crcCount, BC_CRC_COUNT_RESET);
    oscSel();
    runClean();
    runErrors();
    retest();
    stop_test();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    #(25 * 3000);
    nMismatch++;
    stop_test();
  end
endmodule // serial_link_self_test_checker_bench
